// File: design/ftc_pkg.sv
// Shared constants, types and carriers for the flow-through memory block
package ftc_pkg;

    // ==============================================================
    // Array geometry
    // ==============================================================
    localparam int ADDR_W = 19;
    localparam int HI_W = ADDR_W - 2;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;

    // ==============================================================
    // Field positions and reset values
    // ==============================================================
    localparam int SEED_LSB = 0;
    localparam int SEED_W = 2;
    localparam logic [SEED_W-1:0] SEED_RST = 2'h0;
    localparam logic [SEED_W-1:0] STEP_ONE = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
    localparam logic [LANES-1:0] LANES_RST = 4'hf;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
    localparam logic ORDER_RST = 1'h1;
    localparam int SYNC_STAGES = 2;

    // ==============================================================
    // Access state held between clock edges
    // ==============================================================
    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_READ = 2'b01,
        OP_WRITE = 2'b10
    } ftc_op_t;

    // ==============================================================
    // Synchronous control inputs, sampled together
    // ==============================================================
    typedef struct packed {
        logic [HI_W-1:0] addr_hi;
        logic burst_seed_bit1;
        logic burst_seed_bit0;
        logic write_n;
        logic [LANES-1:0] lane_write_n;
        logic advance_or_load;
        logic clock_qualifier_n;
        logic select_low_a;
        logic select_high;
        logic select_low_b;
    } ftc_ctl_t;

endpackage : ftc_pkg

// File: design/ftc_burst_ctr.sv
// Two-bit burst address counter with linear and interleaved order
`timescale 1ns/1ps
module ftc_burst_ctr (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_load,
    input wire logic i_advance,
    input wire logic [ftc_pkg::SEED_W-1:0] i_seed,
    input wire logic i_interleave,
    output logic [ftc_pkg::SEED_W-1:0] o_lsb_nxt
);
    import ftc_pkg::*;

    logic [SEED_W-1:0] seed_r;
    logic [SEED_W-1:0] count_r;
    logic [SEED_W-1:0] count_nxt;
    logic [SEED_W-1:0] lin_lsb;
    logic [SEED_W-1:0] ilv_lsb;

    // ==============================================================
    // Next burst position
    // ==============================================================
    // Count restarts at zero on a load, wraps modulo four on advance
    assign count_nxt = i_load ? SEED_RST : count_r + STEP_ONE;
    assign lin_lsb = seed_r + count_nxt;
    assign ilv_lsb = seed_r ^ count_nxt;
    // Strap picks the order; a load passes the seed straight through
    assign o_lsb_nxt = i_load ? i_seed
                     : (i_interleave ? ilv_lsb : lin_lsb);

    // ==============================================================
    // Seed and count registers
    // ==============================================================
    // Seed taken on load, count stepped on advance
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            seed_r <= SEED_RST;
            count_r <= SEED_RST;
        end
        else if (i_load)
        begin
            seed_r <= i_seed;
            count_r <= SEED_RST;
        end
        else if (i_advance)
        begin
            count_r <= count_nxt;
        end
    end

endmodule : ftc_burst_ctr

// File: design/ftc_sram_core.sv
// Flow-through burst memory: input capture, burst, byte writes, drivers
`timescale 1ns/1ps
module ftc_sram_core (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire ftc_pkg::ftc_ctl_t i_ctl,
    input wire logic i_output_enable_n,
    input wire logic i_burst_order,
    input wire logic [ftc_pkg::DATA_W-1:0] i_dq,
    output logic [ftc_pkg::DATA_W-1:0] o_dq,
    output logic o_dq_oe
);
    import ftc_pkg::*;

    // ==============================================================
    // Declarations
    // ==============================================================
    // Reset release and strap synchroniser
    logic [SYNC_STAGES-1:0] rst_sync_r;
    logic rst_b;
    logic strap_meta_r;
    logic strap_sync_r;
    logic order_r;

    // Access kind and its next value
    ftc_op_t op_r;
    ftc_op_t op_nxt;

    // Address of the running access
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;

    // Lane strobes taken with each address
    logic [LANES-1:0] lanes_r;

    // Held read data and the pin drive flag
    logic [DATA_W-1:0] dq_r;
    logic [DATA_W-1:0] dq_nxt;
    logic drive_r;
    logic drive_nxt;

    // Storage, one word per address, not reset
    logic [DATA_W-1:0] mem_r [DEPTH];

    // Edge qualification and decode
    logic edge_ok;
    logic selected;
    logic do_load;
    logic do_advance;
    logic [SEED_W-1:0] burst_lsb;

    // Write and read paths
    logic commit;
    logic [LANES-1:0] lane_en;
    logic [DATA_W-1:0] old_word;
    logic [DATA_W-1:0] wr_word;
    logic [DATA_W-1:0] rd_word;
    logic bypass;

    // ==============================================================
    // Reset release
    // ==============================================================
    // Two-stage release of the asynchronous reset
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            rst_sync_r <= '0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    assign rst_b = rst_sync_r[SYNC_STAGES-1];

    // ==============================================================
    // Burst-order strap
    // ==============================================================
    // Strap pin passes three flops (two synchroniser stages, then order_r) before any logic reads it
    always_ff @(posedge i_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strap_meta_r <= ORDER_RST;
            strap_sync_r <= ORDER_RST;
        end
        else
        begin
            strap_meta_r <= i_burst_order;
            strap_sync_r <= strap_meta_r;
        end
    end

    // Order follows the settled strap; reset loads interleaved until the strap arrives
    always_ff @(posedge i_clk or negedge rst_b)
    begin
        if (!rst_b)
            order_r <= ORDER_RST;
        else
            order_r <= strap_sync_r;
    end

    // ==============================================================
    // Input qualification and decode
    // ==============================================================
    // Clock qualifier low lets an edge count at all
    assign edge_ok = ~i_ctl.clock_qualifier_n;
    // Three-way select: low, high, low
    assign selected = ~i_ctl.select_low_a & i_ctl.select_high
                    & ~i_ctl.select_low_b;
    // Advance low loads, advance high steps
    assign do_load = edge_ok & ~i_ctl.advance_or_load;
    assign do_advance = edge_ok & i_ctl.advance_or_load;

    // Next access: a load looks at selects and write strobe; an advance
    // continues the running access, so a stale deselect stays deselected
    always_comb
    begin
        op_nxt = op_r;
        if (do_load)
        begin
            if (!selected)
                op_nxt = OP_IDLE;
            else if (!i_ctl.write_n)
                op_nxt = OP_WRITE;
            else
                op_nxt = OP_READ;
        end
    end

    // ==============================================================
    // Address path
    // ==============================================================
    ftc_burst_ctr u_burst (
        .i_clk(i_clk),
        .i_rst_b(rst_b),
        .i_load(do_load),
        .i_advance(do_advance),
        .i_seed({i_ctl.burst_seed_bit1, i_ctl.burst_seed_bit0}),
        .i_interleave(order_r),
        .o_lsb_nxt(burst_lsb)
    );

    // Fresh address on load, burst position on advance
    assign addr_nxt = do_load ? {i_ctl.addr_hi, burst_lsb}
                    : {addr_r[ADDR_W-1:SEED_W], burst_lsb};

    // ==============================================================
    // Write data phase
    // ==============================================================
    // Data for a write arrives one qualified edge after its address
    assign commit = edge_ok & (op_r == OP_WRITE);
    assign old_word = mem_r[addr_r];

    // Per lane: strobe low and write access both needed
    generate
        for (genvar g = 0; g < LANES; g++)
        begin : g_lane
            assign lane_en[g] = commit & ~lanes_r[g];
            assign wr_word[g*LANE_W +: LANE_W] = lane_en[g]
                ? i_dq[g*LANE_W +: LANE_W]
                : old_word[g*LANE_W +: LANE_W];
        end
    endgenerate

    // Storage array, one word per address
    always_ff @(posedge i_clk)
    begin
        if (commit)
            mem_r[addr_r] <= wr_word;
    end

    // ==============================================================
    // Read path
    // ==============================================================
    // A read of the word being written this edge sees the new lanes
    assign bypass = commit & (addr_nxt == addr_r);
    assign rd_word = bypass ? wr_word : mem_r[addr_nxt];

    // ==============================================================
    // Access state
    // ==============================================================
    // Access kind; nothing moves on an edge that the qualifier masks
    always_ff @(posedge i_clk or negedge rst_b)
    begin
        if (!rst_b)
            op_r <= OP_IDLE;
        else if (edge_ok)
            op_r <= op_nxt;
    end

    // Address of the running access, burst bits included
    always_ff @(posedge i_clk or negedge rst_b)
    begin
        if (!rst_b)
            addr_r <= ADDR_RST;
        else if (edge_ok)
            addr_r <= addr_nxt;
    end

    // Lane strobes travel with every address, load or advance alike
    always_ff @(posedge i_clk or negedge rst_b)
    begin
        if (!rst_b)
            lanes_r <= LANES_RST;
        else if (edge_ok)
            lanes_r <= i_ctl.lane_write_n;
    end

    // ==============================================================
    // Output drivers
    // ==============================================================
    // Drive flag for the access taken at this edge; a write data
    // phase and a deselect both leave the pins floating
    always_comb
    begin
        drive_nxt = 1'b0;
        unique case (op_nxt)
            OP_READ:
                drive_nxt = 1'b1;
            OP_WRITE:
                drive_nxt = 1'b0;
            OP_IDLE:
                drive_nxt = 1'b0;
            default:
                drive_nxt = 1'b0;
        endcase
    end

    // Read word replaces the held data only when a read is taken
    assign dq_nxt = drive_nxt ? rd_word : dq_r;

    // Held read data, frozen on a masked edge
    always_ff @(posedge i_clk or negedge rst_b)
    begin
        if (!rst_b)
            dq_r <= DATA_RST;
        else if (edge_ok)
            dq_r <= dq_nxt;
    end

    // Drive only rises at the edge that samples a select, so the clock
    // on which a device leaves deselect has its pins floating
    always_ff @(posedge i_clk or negedge rst_b)
    begin
        if (!rst_b)
            drive_r <= 1'b0;
        else if (edge_ok)
            drive_r <= drive_nxt;
    end

    assign o_dq = dq_r;
    // Output enable acts without the clock, masked by the drive flag
    assign o_dq_oe = drive_r & ~i_output_enable_n;

endmodule : ftc_sram_core

// File: tb/ftc_sram_core_assertions.sv
// Port-level checks for the flow-through memory block
`timescale 1ns/1ps
module ftc_sram_core_assertions (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire ftc_pkg::ftc_ctl_t i_ctl,
    input wire logic i_output_enable_n,
    input wire logic i_burst_order,
    input wire logic [ftc_pkg::DATA_W-1:0] i_dq,
    input wire logic [ftc_pkg::DATA_W-1:0] o_dq,
    input wire logic o_dq_oe
);
    import ftc_pkg::*;
    logic take;
    logic load;
    logic sel;
    // Qualified edge, load and chip select decode
    assign take = !i_ctl.clock_qualifier_n;
    assign load = take && !i_ctl.advance_or_load;
    assign sel = !i_ctl.select_low_a && i_ctl.select_high
        && !i_ctl.select_low_b;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // ==============================================================
    // Driver enable and freeze
    // ==============================================================
    oe_high_float_a: assert property (
        i_output_enable_n |-> !o_dq_oe)
        else $error("drivers on with output enable high");
    write_float_a: assert property (
        load && sel && !i_ctl.write_n |=> !o_dq_oe)
        else $error("drivers on in write data phase");
    desel_float_a: assert property (
        load && !sel |=> !o_dq_oe)
        else $error("drivers on while deselected");
    read_drive_a: assert property (
        load && sel && i_ctl.write_n |=> o_dq_oe == !i_output_enable_n)
        else $error("read drive enable wrong");
    freeze_data_a: assert property (
        !take |=> $stable(o_dq))
        else $error("data changed on ignored edge");
    freeze_drive_a: assert property (
        !take ##1 $stable(i_output_enable_n) |-> $stable(o_dq_oe))
        else $error("drive changed on ignored edge");
    adv_desel_a: assert property (
        (load && !sel) ##1 (take && i_ctl.advance_or_load) |=> !o_dq_oe)
        else $error("advance left deselected state");
    freeze_keep_a: assert property (
        (load && sel && i_ctl.write_n) ##1 (!take) [*3]
        |=> (o_dq_oe || i_output_enable_n))
        else $error("freeze dropped the read");
endmodule : ftc_sram_core_assertions

// File: tb/ftc_master_model.sv
// Bus master model driving the memory's synchronous inputs
`timescale 1ns/1ps
module ftc_master_model (
    input wire logic i_clk,
    output ftc_pkg::ftc_ctl_t o_ctl,
    output logic o_oe_n,
    output logic [ftc_pkg::DATA_W-1:0] o_dq
);
    import ftc_pkg::*;
    // Idle at time zero: edges ignored, deselected, outputs off
    initial
    begin
        o_ctl = '0;
        o_ctl.clock_qualifier_n = 1'b1;
        o_ctl.select_low_a = 1'b1;
        o_oe_n = 1'b1;
        o_dq = 36'h5a5a5a5a5;
    end
    // One cycle, called at a falling edge, held to the next one
    task automatic step(input ftc_ctl_t c, input logic [DATA_W-1:0] d,
        input logic drv);
        o_ctl = c;
        o_dq = drv ? d : ~o_dq; // Released lines never keep old value
        @(negedge i_clk);
    endtask : step
    task automatic set_oe(input logic v);
        o_oe_n = v;
    endtask : set_oe
endmodule : ftc_master_model

// File: tb/flow_through_sram_ctrl_inputs_tb.sv
// Self-checking bench for the flow-through memory input logic
`timescale 1ns/1ps
module flow_through_sram_ctrl_inputs_tb;
    import ftc_pkg::*;
    localparam logic [HI_W-1:0] HI = 17'h169ad;
    localparam logic [DATA_W-1:0] MSK = 36'h007fc01ff;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_burst_order = 1'b0;
    ftc_ctl_t ctl;
    logic oe_n;
    logic [DATA_W-1:0] dq_in;
    logic [DATA_W-1:0] o_dq;
    logic o_dq_oe;
    int bad_count = 0;
    int checks = 0;
    // ==============================================================
    // Clock, master and block
    // ==============================================================
    always #25 i_clk = ~i_clk;
    ftc_master_model master (.i_clk(i_clk), .o_ctl(ctl), .o_oe_n(oe_n),
        .o_dq(dq_in));
    ftc_sram_core uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ctl(ctl),
        .i_output_enable_n(oe_n), .i_burst_order(i_burst_order),
        .i_dq(dq_in), .o_dq(o_dq), .o_dq_oe(o_dq_oe));
    // ==============================================================
    // Helpers
    // ==============================================================
    task automatic check(input logic [DATA_W-1:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    function automatic ftc_ctl_t mk(input logic [1:0] lo, input logic wr_n,
        input logic [3:0] ln, input logic adv, input logic [2:0] sel);
        mk = '0;
        mk.addr_hi = HI;
        {mk.burst_seed_bit1, mk.burst_seed_bit0} = lo;
        mk.write_n = wr_n;
        mk.lane_write_n = ln;
        mk.advance_or_load = adv;
        {mk.select_low_a, mk.select_high, mk.select_low_b} = sel;
    endfunction : mk
    // Frozen cycle carrying a write attempt that must be ignored
    function automatic ftc_ctl_t frz();
        frz = mk(2'h3, 1'b0, 4'h0, 1'b0, 3'b010);
        frz.clock_qualifier_n = 1'b1;
    endfunction : frz
    function automatic logic [DATA_W-1:0] dv(input int k);
        dv = 36'h9a5c3e100 + DATA_W'(k);
    endfunction : dv
    task automatic rd(input logic [1:0] lo, input logic [DATA_W-1:0] d,
        input logic drv);
        master.step(mk(lo, 1'b1, 4'hf, 1'b0, 3'b010), d, drv);
    endtask : rd
    task automatic wr(input logic [1:0] lo, input logic [3:0] ln,
        input logic [DATA_W-1:0] d, input logic drv);
        master.step(mk(lo, 1'b0, ln, 1'b0, 3'b010), d, drv);
    endtask : wr
    // Lane strobes ride with every beat; low keeps burst writes whole
    task automatic nx(input logic [DATA_W-1:0] d, input logic drv);
        master.step(mk(2'h0, 1'b1, 4'h0, 1'b1, 3'b010), d, drv);
    endtask : nx
    // ==============================================================
    // Scenarios
    // ==============================================================
    task automatic do_reset(input logic order);
        master.step(frz(), '0, 1'b0);
        i_rst_b = 1'b0;
        i_burst_order = order;
        repeat (20) @(negedge i_clk);
        check(o_dq_oe, 1'b0);
        check(o_dq, DATA_RST);
        i_rst_b = 1'b1;
        repeat (6) @(negedge i_clk);
    endtask : do_reset
    task automatic t_write_read();
        master.set_oe(1'b0);
        wr(2'h0, 4'h0, '0, 1'b0);
        check(o_dq_oe, 1'b0);
        wr(2'h1, 4'h0, dv(10), 1'b1);
        check(o_dq_oe, 1'b0);
        wr(2'h0, 4'ha, dv(11), 1'b1);
        rd(2'h0, 36'hfffffffff, 1'b1);
        check(o_dq, dv(10) | MSK);
        check(o_dq_oe, 1'b1);
        master.step(mk(2'h1, 1'b1, 4'h0, 1'b0, 3'b010), '0, 1'b1);
        check(o_dq, dv(11));
        rd(2'h1, '0, 1'b0);
        check(o_dq, dv(11));
    endtask : t_write_read
    task automatic t_burst_linear();
        wr(2'h2, 4'h0, '0, 1'b0);
        for (int k = 0; k < 3; k++)
            nx(dv(k), 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            if (k == 0)
                rd(2'h1, dv(3), 1'b1);
            else
                nx('0, 1'b0);
            check(o_dq, dv((3 + k) & 3));
            if (k == 1)
            begin
                master.step(frz(), '0, 1'b1);
                check(o_dq, dv(0));
            end
        end
    endtask : t_burst_linear
    task automatic t_selects();
        for (int s = 0; s < 8; s++)
        begin
            master.step(mk(2'h0, 1'b1, 4'hf, 1'b0, 3'(s)), '0, 1'b0);
            check(o_dq_oe, DATA_W'(s == 2));
        end
        nx('0, 1'b0);
        check(o_dq_oe, 1'b0);
        rd(2'h3, '0, 1'b0);
        check(o_dq_oe, 1'b1);
        master.set_oe(1'b1);
        #1 check(o_dq_oe, 1'b0);
        master.set_oe(1'b0);
        #1 check(o_dq_oe, 1'b1);
    endtask : t_selects
    task automatic t_interleave();
        for (int k = 0; k < 4; k++)
        begin
            if (k == 0)
                rd(2'h3, '0, 1'b0);
            else
                nx('0, 1'b0);
            check(o_dq, dv(((3 ^ k) + 2) & 3));
            if (k == 0)
            begin
                repeat (3) master.step(frz(), '0, 1'b1);
                check(o_dq, dv(1));
            end
        end
    endtask : t_interleave
    task automatic final_report();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    // Main sequence and watchdog
    initial
    begin
        do_reset(1'b0);
        t_write_read();
        t_burst_linear();
        t_selects();
        do_reset(1'b1);
        t_interleave();
        final_report();
    end
    initial
    begin
        #100000;
        bad_count++;
        final_report();
    end
endmodule : flow_through_sram_ctrl_inputs_tb
bind ftc_sram_core ftc_sram_core_assertions chk (.i_clk(i_clk),
    .i_rst_b(i_rst_b), .i_ctl(i_ctl), .i_output_enable_n(i_output_enable_n),
    .i_burst_order(i_burst_order), .i_dq(i_dq), .o_dq(o_dq),
    .o_dq_oe(o_dq_oe));
